// File: flash_ctl_pkg.sv
// Purpose: shared constants for the flash command controller
// Assumes: byte-wide flash with command writes and status polling
// Notes: command codes, status bit positions, pin timing counts
`default_nettype none
package flash_ctl_pkg;
  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;
  localparam logic [7:0] CMD_PROGRAM_ALT = 8'h10;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK_BLOCK = 8'h01;
  localparam logic [7:0] CMD_LOCK_MASTER = 8'hF1;
  // ****************************************
  // identifier offsets and status bits
  // ****************************************
  localparam logic [23:0] ID_MAKER_ADDR = 24'h000000;
  localparam logic [23:0] ID_DEVICE_ADDR = 24'h000001;
  localparam logic [23:0] ID_BLOCK_LOCK_OFS = 24'h000002;
  localparam logic [23:0] ID_MASTER_ADDR = 24'h000003;
  localparam int ST_READY = 7;
  localparam int ST_ERASE_ERR = 5;
  localparam int ST_PROG_ERR = 4;
  localparam int ST_SUPPLY_LOW = 3;
  localparam int ST_LOCK_VIOL = 1;
  localparam int LOCK_BIT = 0;
  // ****************************************
  // bus timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int STROBE_NS = 60;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 8;
  // operation kinds at the user port
  typedef enum logic [3:0] {
    OP_READ_ARRAY, OP_READ_ID, OP_READ_STATUS, OP_CLEAR_STATUS, OP_ERASE,
    OP_PROGRAM, OP_SUSPEND, OP_RESUME, OP_LOCK_BLOCK, OP_LOCK_MASTER,
    OP_CLEAR_LOCKS, OP_READ
  } op_t;
endpackage : flash_ctl_pkg
`default_nettype wire

// File: flash_bus_cycle.sv
// Purpose: one asynchronous bus cycle, read or write, on the flash pins
// Assumes: strobes active low; data pins shared
// Notes: write data latched by the flash on the rising write strobe
`default_nettype none
module flash_bus_cycle
  import flash_ctl_pkg::*;
#(
  parameter int ADDR_W = 24
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // cycle request
  input wire logic start_in,
  input wire logic write_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic done_out,
  output logic [7:0] rdata_out,
  // flash pins
  output logic [ADDR_W-1:0] addr_out,
  output logic chip_enable_n_out,
  output logic output_enable_n_out,
  output logic write_enable_n_out,
  output logic [7:0] dq_out,
  output logic dq_oe_out,
  input wire logic [7:0] dq_in
);
  typedef enum logic [1:0] {B_IDLE, B_STROBE, B_RELEASE} bstate_t;
  bstate_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [7:0] wd_q, wd_d, rd_q, rd_d;
  logic [7:0] dq_s1_q, dq_s2_q;
  // ****************************************
  // data pin synchroniser
  // ****************************************
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
    end else begin
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
    end
  end
  // ****************************************
  // cycle sequencer
  // ****************************************
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    addr_d = addr_q;
    wd_d = wd_q;
    rd_d = rd_q;
    case (st_q)
      B_IDLE: begin
        if (start_in) begin
          st_d = B_STROBE;
          wr_d = write_in;
          addr_d = addr_in;
          wd_d = wdata_in;
          cnt_d = CNT_W'(STROBE_CYC + 2);
        end
      end
      B_STROBE: begin
        if (cnt_q == '0) begin
          st_d = B_RELEASE;
          rd_d = dq_s2_q; // sampled after strobe settle plus sync delay
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      B_RELEASE: st_d = B_IDLE;
      default: st_d = B_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= B_IDLE;
      cnt_q <= '0;
      wr_q <= 1'b0;
      addr_q <= '0;
      wd_q <= 8'h00;
      rd_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
    end
  end
  // pin drive; each read drops the strobes so status relatches
  assign addr_out = addr_q;
  // select held through release so the write strobe rises first
  assign chip_enable_n_out = (st_q == B_IDLE);
  assign output_enable_n_out = !(st_q == B_STROBE && !wr_q);
  assign write_enable_n_out = !(st_q == B_STROBE && wr_q);
  assign dq_out = wd_q;
  assign dq_oe_out = wr_q && (st_q != B_IDLE);
  assign done_out = (st_q == B_RELEASE);
  assign rdata_out = rd_q;
endmodule : flash_bus_cycle
`default_nettype wire

// File: flash_host_ctl.sv
// Purpose: host-side controller issuing command sequences to a byte-wide flash
// Assumes: user gives one operation at a time; flash pins asynchronous
// Notes: busy operations end when both ready_busy_n and the status ready bit show ready
//
// How it works
// - erase writes 20H then D0H both at block address
// - program writes 40H then address and byte
// - suspend B0H and resume D0H, single write, any address
// - block lock writes 60H then 01H within block
// - master lock writes 60H then F1H, needs override level
// - host waits on both ready_busy_n and status bit 7, then checks errors
`default_nettype none
module flash_host_ctl
  import flash_ctl_pkg::*;
#(
  parameter int ADDR_W = 24
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // user request
  input wire logic req_valid_in,
  input wire logic [3:0] req_op_in,
  input wire logic [ADDR_W-1:0] req_addr_in,
  input wire logic [7:0] req_data_in,
  input wire logic override_in,
  output logic req_ready_out,
  // user answer
  output logic done_out,
  output logic [7:0] rdata_out,
  output logic [7:0] status_out,
  output logic error_out,
  output logic refused_out,
  output logic suspended_out,
  // flash pins
  output logic [ADDR_W-1:0] addr_out,
  output logic chip_enable_n_out,
  output logic output_enable_n_out,
  output logic write_enable_n_out,
  output logic [7:0] dq_out,
  output logic dq_oe_out,
  input wire logic [7:0] dq_in,
  output logic reset_powerdown_n_out,
  output logic high_override_level_out,
  input wire logic ready_busy_n_in
);
  typedef enum logic [2:0] {S_IDLE, S_CYC1, S_CYC2, S_POLL, S_DONE} state_t;
  state_t st_q, st_d;
  op_t op_q, op_d;
  logic [ADDR_W-1:0] a_q, a_d;
  logic [7:0] d_q, d_d, rd_q, rd_d, stat_q, stat_d;
  logic err_q, err_d, ref_q, ref_d, susp_q, susp_d, busy_q, busy_d, ovr_q, ovr_d;
  logic rb_s1_q, rb_s2_q;
  logic cyc_start, cyc_write, cyc_done;
  logic [ADDR_W-1:0] cyc_addr;
  logic [7:0] cyc_wdata, cyc_rdata;
  // ****************************************
  // ready pin synchroniser
  // ****************************************
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
    end else begin
      rb_s1_q <= ready_busy_n_in;
      rb_s2_q <= rb_s1_q;
    end
  end
  // ****************************************
  // first-cycle code per operation
  // ****************************************
  function automatic logic [7:0] first_code(input op_t op);
    case (op)
      OP_READ_ARRAY: first_code = CMD_READ_ARRAY;
      OP_READ_ID: first_code = CMD_READ_ID;
      OP_READ_STATUS: first_code = CMD_READ_STATUS;
      OP_CLEAR_STATUS: first_code = CMD_CLEAR_STATUS;
      OP_ERASE: first_code = CMD_ERASE_SETUP;
      OP_PROGRAM: first_code = CMD_PROGRAM_SETUP;
      OP_SUSPEND: first_code = CMD_SUSPEND;
      OP_RESUME: first_code = CMD_CONFIRM;
      OP_LOCK_BLOCK, OP_LOCK_MASTER, OP_CLEAR_LOCKS: first_code = CMD_LOCK_SETUP;
      default: first_code = CMD_READ_ARRAY;
    endcase
  endfunction : first_code
  // second-cycle code for two-write sequences
  function automatic logic [7:0] second_code(input op_t op, input logic [7:0] d);
    case (op)
      OP_ERASE: second_code = CMD_CONFIRM;
      OP_PROGRAM: second_code = d;
      OP_LOCK_BLOCK: second_code = CMD_LOCK_BLOCK;
      OP_LOCK_MASTER: second_code = CMD_LOCK_MASTER;
      default: second_code = CMD_CONFIRM;
    endcase
  endfunction : second_code
  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    a_d = a_q;
    d_d = d_q;
    rd_d = rd_q;
    stat_d = stat_q;
    err_d = err_q;
    ref_d = 1'b0;
    susp_d = susp_q;
    busy_d = busy_q;
    ovr_d = ovr_q;
    cyc_start = 1'b0;
    cyc_write = 1'b1;
    cyc_addr = a_q;
    cyc_wdata = first_code(op_q);
    case (st_q)
      S_IDLE: begin
        if (req_valid_in) begin
          op_d = op_t'(req_op_in);
          a_d = req_addr_in;
          d_d = req_data_in;
          ovr_d = override_in;
          if ((op_t'(req_op_in) == OP_READ_ARRAY && busy_q && !susp_q) ||
              (op_t'(req_op_in) == OP_CLEAR_STATUS && susp_q)) begin
            ref_d = 1'b1;
            st_d = S_DONE;
          end else begin
            st_d = S_CYC1;
          end
        end
      end
      S_CYC1: begin
        cyc_start = 1'b1;
        cyc_write = (op_q != OP_READ);
        if (cyc_done) begin
          cyc_start = 1'b0;
          rd_d = cyc_rdata;
          case (op_q)
            OP_ERASE, OP_PROGRAM, OP_LOCK_BLOCK, OP_LOCK_MASTER, OP_CLEAR_LOCKS:
              st_d = S_CYC2;
            OP_SUSPEND: begin
              susp_d = 1'b1;
              st_d = S_POLL;
            end
            OP_RESUME: begin
              susp_d = 1'b0;
              busy_d = 1'b1;
              st_d = S_POLL;
            end
            default: st_d = S_DONE;
          endcase
        end
      end
      S_CYC2: begin
        cyc_start = 1'b1;
        cyc_wdata = second_code(op_q, d_q);
        if (cyc_done) begin
          cyc_start = 1'b0;
          busy_d = 1'b1;
          st_d = S_POLL;
        end
      end
      S_POLL: begin
        // flash is in status mode, so plain reads return status
        cyc_start = 1'b1;
        cyc_write = 1'b0;
        if (cyc_done) begin
          cyc_start = 1'b0;
          stat_d = cyc_rdata;
          if (cyc_rdata[ST_READY] && rb_s2_q) begin
            busy_d = 1'b0;
            err_d = cyc_rdata[ST_ERASE_ERR] | cyc_rdata[ST_PROG_ERR] |
                    cyc_rdata[ST_SUPPLY_LOW] | cyc_rdata[ST_LOCK_VIOL];
            st_d = S_DONE;
          end
        end
      end
      S_DONE: st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= S_IDLE;
      op_q <= OP_READ_ARRAY;
      a_q <= '0;
      d_q <= 8'h00;
      rd_q <= 8'h00;
      stat_q <= 8'h80;
      err_q <= 1'b0;
      ref_q <= 1'b0;
      susp_q <= 1'b0;
      busy_q <= 1'b0;
      ovr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      a_q <= a_d;
      d_q <= d_d;
      rd_q <= rd_d;
      stat_q <= stat_d;
      err_q <= err_d;
      ref_q <= ref_d;
      susp_q <= susp_d;
      busy_q <= busy_d;
      ovr_q <= ovr_d;
    end
  end
  // ****************************************
  // bus cycle engine
  // ****************************************
  flash_bus_cycle #(.ADDR_W(ADDR_W)) u_cycle (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .start_in(cyc_start),
    .write_in(cyc_write),
    .addr_in(cyc_addr),
    .wdata_in(cyc_wdata),
    .done_out(cyc_done),
    .rdata_out(cyc_rdata),
    .addr_out(addr_out),
    .chip_enable_n_out(chip_enable_n_out),
    .output_enable_n_out(output_enable_n_out),
    .write_enable_n_out(write_enable_n_out),
    .dq_out(dq_out),
    .dq_oe_out(dq_oe_out),
    .dq_in(dq_in)
  );
  // outputs; reset pin follows system reset, override held from the request
  assign req_ready_out = (st_q == S_IDLE);
  assign done_out = (st_q == S_DONE);
  assign rdata_out = rd_q;
  assign status_out = stat_q;
  assign error_out = err_q;
  assign refused_out = ref_q;
  assign suspended_out = susp_q;
  assign reset_powerdown_n_out = !rst_in;
  assign high_override_level_out = ovr_q;
endmodule : flash_host_ctl
`default_nettype wire

// File: flash_host_ctl_chk.sv
// Purpose: pin and handshake checks for the flash host controller
// Assumes: bound to flash_host_ctl, one clock domain
// Notes: write strobe length is STROBE_CYC+3 cycles
`default_nettype none
module flash_host_ctl_chk
  import flash_ctl_pkg::*;
(
  // watched ports
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic req_ready_out,
  input wire logic done_out,
  input wire logic refused_out,
  input wire logic [7:0] status_out,
  input wire logic chip_enable_n_out,
  input wire logic output_enable_n_out,
  input wire logic write_enable_n_out,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // ****
  // pin and answer relations
  // ****
  a_strobe_held: assert property ($fell(write_enable_n_out) |-> !write_enable_n_out[*8])
    else $error("write strobe too short");
  a_data_stable: assert property (!write_enable_n_out && !$past(write_enable_n_out)
    |-> $stable(dq_out))
    else $error("write data moved under strobe");
  a_write_cycle: assert property (!write_enable_n_out
    |-> dq_oe_out && !chip_enable_n_out && output_enable_n_out)
    else $error("bad write cycle pins");
  a_read_nodrive: assert property (!output_enable_n_out |-> !dq_oe_out)
    else $error("data driven during read");
  a_status_reset: assert property ($fell(rst_in) |-> status_out == 8'h80)
    else $error("status not ready after reset");
  a_done_pulse: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  a_refuse_quiet: assert property (refused_out |-> done_out && chip_enable_n_out)
    else $error("refusal without done or with bus active");
  a_ready_after: assert property (done_out |=> req_ready_out)
    else $error("not ready after done");
  a_oe_relatch: assert property ($rose(output_enable_n_out) |=> output_enable_n_out)
    else $error("output enable high too briefly");
endmodule : flash_host_ctl_chk

bind flash_host_ctl flash_host_ctl_chk flash_host_ctl_chk_i (.ref_clk_in, .rst_in,
  .req_ready_out, .done_out, .refused_out, .status_out, .chip_enable_n_out,
  .output_enable_n_out, .write_enable_n_out, .dq_out, .dq_oe_out);
`default_nettype wire

// File: flash_dev_model.sv
// Purpose: behavioural byte-wide flash as seen at its pins
// Assumes: four blocks of sixteen bytes, block from address bits 17:16
// Notes: algorithm time in ns from busy_ns_in
`default_nettype none
module flash_dev_model
  import flash_ctl_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5C, // arbitrary value
  parameter logic [7:0] PART_CODE = 8'h3E // arbitrary value
) (
  // pins
  input wire logic [23:0] addr_in,
  input wire logic chip_enable_n_in,
  input wire logic output_enable_n_in,
  input wire logic write_enable_n_in,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  input wire logic reset_powerdown_n_in,
  input wire logic high_override_level_in,
  output logic ready_busy_n_out,
  // test controls
  input wire logic supply_low_in,
  input wire logic [31:0] busy_ns_in
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef enum logic [1:0] {M_ARRAY, M_ID, M_STATUS} mode_t;
  mode_t mode = M_ARRAY;
  logic [7:0] mem [64];
  logic [3:0] locks = 4'h0;
  logic master = 1'b0;
  logic susp = 1'b0;
  logic [7:0] pend = 8'h00;
  logic [7:0] sr = 8'h00;
  logic [7:0] lat = 8'h80;
  logic [7:0] last = 8'h00;
  logic [7:0] rd;
  int busy = 0;
  wire [1:0] blk = addr_in[17:16];
  wire [5:0] idx = {blk, addr_in[3:0]};
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // algorithm time runs down unless suspended
  always #1 if (busy > 0 && !susp) busy = busy - 1;
  // power-down: array mode, status ready, abort
  always @(negedge reset_powerdown_n_in) begin
    mode = M_ARRAY;
    sr = 8'h00;
    busy = 0;
    susp = 1'b0;
    pend = 8'h00;
  end
  // commands taken on the rising write strobe
  always @(posedge write_enable_n_in) if (!chip_enable_n_in && reset_powerdown_n_in) begin
    if (pend == 8'h00) case (dq_in)
      CMD_READ_ARRAY: if (busy == 0 || susp) mode = M_ARRAY;
      CMD_READ_ID: mode = M_ID;
      CMD_READ_STATUS: mode = M_STATUS;
      CMD_CLEAR_STATUS: if (!susp) sr = 8'h00;
      CMD_SUSPEND: begin
        susp = busy > 0;
        mode = M_STATUS;
      end
      CMD_CONFIRM: begin
        susp = 1'b0;
        mode = M_STATUS;
      end
      default: pend = dq_in;
    endcase
    else begin
      mode = M_STATUS;
      if (pend == CMD_LOCK_SETUP) begin
        if (dq_in != CMD_LOCK_BLOCK && dq_in != CMD_LOCK_MASTER && dq_in != CMD_CONFIRM)
          sr = sr | 8'h30;
        else if ((master || dq_in == CMD_LOCK_MASTER) && !high_override_level_in)
          sr = sr | (dq_in == CMD_CONFIRM ? 8'h22 : 8'h12);
        else begin
          busy = busy_ns_in;
          if (dq_in == CMD_LOCK_BLOCK) locks[blk] = 1'b1;
          if (dq_in == CMD_LOCK_MASTER) master = 1'b1;
          if (dq_in == CMD_CONFIRM) locks = 4'h0;
        end
      end
      else if (pend == CMD_ERASE_SETUP && dq_in != CMD_CONFIRM) sr = sr | 8'h30;
      else if (supply_low_in) sr = sr | 8'h28;
      else if (locks[blk] && !high_override_level_in)
        sr = sr | (pend == CMD_ERASE_SETUP ? 8'h22 : 8'h12);
      else begin
        busy = busy_ns_in;
        if (pend == CMD_ERASE_SETUP) for (int i = 0; i < 16; i++) mem[{blk, i[3:0]}] = 8'hFF;
        else mem[idx] = mem[idx] & dq_in;
      end
      pend = 8'h00;
    end
  end
  // status latched at the falling output enable
  always @(negedge output_enable_n_in) lat = {busy == 0 || susp, susp, sr[5:0]};
  always @(posedge output_enable_n_in) last = rd;
  always_comb case (mode)
    M_ARRAY: rd = mem[idx];
    M_ID: rd = addr_in[1:0] == 2'h0 ? MAKER_CODE : addr_in[1:0] == 2'h1 ? PART_CODE
      : {7'h00, addr_in[0] ? master : locks[blk]};
    default: rd = lat;
  endcase
  assign dq_out = (!chip_enable_n_in && !output_enable_n_in) ? rd : ~last;
  assign ready_busy_n_out = !reset_powerdown_n_in || busy == 0 || susp;
endmodule : flash_dev_model
`default_nettype wire

// File: flash_host_ctl_bench.sv
// Purpose: self-checking bench for the flash host controller
// Assumes: behavioural flash model on the pins
// Notes: expected codes come from the model parameters set here
`default_nettype none
module flash_host_ctl_bench
  import flash_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MAKER = 8'h5C; // arbitrary value
  localparam logic [7:0] PART = 8'h3E; // arbitrary value
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic req_valid_in = 1'b0;
  logic [3:0] req_op_in = 4'h0;
  logic [23:0] req_addr_in = 24'h000000;
  logic [7:0] req_data_in = 8'h00;
  logic override_in = 1'b0;
  logic supply_low = 1'b0;
  int busy_ns = 200;
  logic req_ready_out, done_out, error_out, refused_out, suspended_out, dq_oe_out;
  logic chip_enable_n_out, output_enable_n_out, write_enable_n_out;
  logic reset_powerdown_n_out, high_override_level_out, ready_busy_n_in;
  logic [7:0] rdata_out, status_out, dq_out, dev_dq;
  logic [23:0] addr_out;
  int n_mismatch = 0;
  int n_tests = 0;
  wire [7:0] dq_in = dq_oe_out ? dq_out : dev_dq;
  always #5 ref_clk_in = ~ref_clk_in;
  flash_host_ctl flash_host_ctl_i (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
    .req_op_in(req_op_in), .req_addr_in(req_addr_in), .req_data_in(req_data_in),
    .override_in(override_in), .req_ready_out(req_ready_out), .done_out(done_out),
    .rdata_out(rdata_out), .status_out(status_out), .error_out(error_out),
    .refused_out(refused_out), .suspended_out(suspended_out), .addr_out(addr_out),
    .chip_enable_n_out(chip_enable_n_out), .output_enable_n_out(output_enable_n_out),
    .write_enable_n_out(write_enable_n_out), .dq_out(dq_out), .dq_oe_out(dq_oe_out),
    .dq_in(dq_in), .reset_powerdown_n_out(reset_powerdown_n_out),
    .high_override_level_out(high_override_level_out), .ready_busy_n_in(ready_busy_n_in));
  flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) flash_dev_model_i (
    .addr_in(addr_out), .chip_enable_n_in(chip_enable_n_out),
    .output_enable_n_in(output_enable_n_out), .write_enable_n_in(write_enable_n_out),
    .dq_in(dq_in), .dq_out(dev_dq), .reset_powerdown_n_in(reset_powerdown_n_out),
    .high_override_level_in(high_override_level_out), .ready_busy_n_out(ready_busy_n_in),
    .supply_low_in(supply_low), .busy_ns_in(busy_ns));
  // ****
  // shared tasks
  // ****
  task automatic conclude();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic op(input op_t o, input logic [23:0] a, input logic [7:0] d, input logic v);
    int k;
    @(posedge ref_clk_in);
    req_op_in <= o;
    req_addr_in <= a;
    req_data_in <= d;
    override_in <= v;
    req_valid_in <= 1'b1;
    @(posedge ref_clk_in);
    req_valid_in <= 1'b0;
    for (k = 0; k < 20000 && done_out !== 1'b1; k++) @(negedge ref_clk_in);
    if (done_out !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
  endtask : op
  task automatic rd(input logic [23:0] a, input logic [7:0] e);
    op(OP_READ, a, 8'h00, 1'b0);
    check(rdata_out, e);
  endtask : rd
  // check polled status, then clear it
  task automatic stc(input logic [7:0] e);
    check(status_out, e);
    op(OP_CLEAR_STATUS, 24'h000000, 8'h00, 1'b0);
  endtask : stc
  // ****
  // scenarios
  // ****
  task automatic t_reset();
    @(posedge ref_clk_in);
    rst_in <= 1'b1;
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(negedge ref_clk_in);
    check(status_out, 8'h80);
    rd(24'h010005, 8'hFF);
    $display("reset test over");
  endtask : t_reset
  task automatic t_prog();
    op(OP_PROGRAM, 24'h010005, 8'hA5, 1'b0);
    stc(8'h80);
    op(OP_READ_ARRAY, 24'h000000, 8'h00, 1'b0);
    rd(24'h010005, 8'hA5);
    op(OP_PROGRAM, 24'h010005, 8'h5A, 1'b0);
    op(OP_READ_ARRAY, 24'h000000, 8'h00, 1'b0);
    rd(24'h010005, 8'h00);
    busy_ns = 2000;
    op(OP_ERASE, 24'h010000, 8'h00, 1'b0);
    stc(8'h80);
    busy_ns = 200;
    op(OP_READ_ARRAY, 24'h000000, 8'h00, 1'b0);
    rd(24'h01000F, 8'hFF);
    $display("program and erase test over");
  endtask : t_prog
  // suspend with nothing running, refused clear, resume
  task automatic t_susp();
    op(OP_SUSPEND, 24'h000000, 8'h00, 1'b0);
    check({7'h00, suspended_out}, 8'h01);
    op(OP_CLEAR_STATUS, 24'h000000, 8'h00, 1'b0);
    check({7'h00, refused_out}, 8'h01);
    op(OP_RESUME, 24'h000000, 8'h00, 1'b0);
    check({7'h00, suspended_out}, 8'h00);
    check(status_out, 8'h80);
    $display("suspend test over");
  endtask : t_susp
  task automatic t_lock();
    op(OP_LOCK_BLOCK, 24'h020000, 8'h00, 1'b0);
    op(OP_READ_ID, 24'h000000, 8'h00, 1'b0);
    rd(24'h000000, MAKER);
    rd(24'h000001, PART);
    rd(24'h020002, 8'h01);
    op(OP_PROGRAM, 24'h020001, 8'h00, 1'b0);
    check({7'h00, error_out}, 8'h01);
    stc(8'h92);
    op(OP_READ_STATUS, 24'h000000, 8'h00, 1'b0);
    rd(24'h000000, 8'h80);
    op(OP_ERASE, 24'h020000, 8'h00, 1'b0);
    stc(8'hA2);
    op(OP_ERASE, 24'h020000, 8'h00, 1'b1);
    stc(8'h80);
    supply_low = 1'b1;
    op(OP_PROGRAM, 24'h000001, 8'h00, 1'b0);
    stc(8'hA8);
    op(OP_ERASE, 24'h000000, 8'h00, 1'b0);
    stc(8'hA8);
    supply_low = 1'b0;
    $display("lock and supply test over");
  endtask : t_lock
  task automatic t_master();
    op(OP_LOCK_MASTER, 24'h000000, 8'h00, 1'b0);
    stc(8'h92);
    op(OP_LOCK_MASTER, 24'h000000, 8'h00, 1'b1);
    stc(8'h80);
    op(OP_CLEAR_LOCKS, 24'h000000, 8'h00, 1'b0);
    stc(8'hA2);
    op(OP_CLEAR_LOCKS, 24'h000000, 8'h00, 1'b1);
    stc(8'h80);
    op(OP_READ_ID, 24'h000000, 8'h00, 1'b0);
    rd(24'h000003, 8'h01);
    rd(24'h020002, 8'h00);
    $display("master lock test over");
  endtask : t_master
  initial begin
    t_reset();
    t_prog();
    t_susp();
    t_lock();
    t_master();
    t_reset();
    conclude();
  end
endmodule : flash_host_ctl_bench
`default_nettype wire
